//--- logic/rtc_calendar.sv
`timescale 1ns/10ps
// How it works
// R1: Month is five-bit BCD, January default
// R2: Year is two BCD digits, default zero
// R3: Bus access freezes time counters 04h-0Ah
// R4: After access, apply one stored increment
// R5: Master finishes each access within one second
// R6: Master accesses whole time in one go
// R7: Read: write pointer 04h, restart, read seven
// R8: Second alarm: bit 7 disables, BCD 0-59
// R9: Minute alarm: bit 7 disables, BCD 0-59
// R10: Hour alarm: disable, bit 6 zero, 12/24
// R11: Day alarm: disable, bit 6 zero, 1-31
// R12: Alarm when all enabled fields match
module rtc_calendar #(
  parameter int unsigned TICK_DIV = rtc_pkg::TICK_DIV_DEF
) (
  // Clocks, reset, enable
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic osc_clk,
  // Mode strap: high selects 12-hour counting
  input  wire logic hour_12_mode,
  // Serial bus pins
  input  wire logic scl,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_n,
  // Alarm condition
  output logic      alarm
);
  logic [1:0]  ce_o_q;
  logic [31:0] div_q, div_d;
  logic        tg_q, tg_d;
  logic [2:0]  tg_s_q;
  logic [1:0]  mode_s_q;
  logic        tick, busy, wr_en, pend_q, pend_d, alarm_q, alarm_d;
  logic [7:0]  wr_addr, wr_data, rd_addr, rd_data;
  logic [7:0]  sec_q, sec_d, min_q, min_d, hr_q, hr_d, day_q, day_d;
  logic [7:0]  wd_q, wd_d, mon_q, mon_d, yr_q, yr_d;
  logic [7:0]  al_s_q, al_s_d, al_m_q, al_m_d, al_h_q, al_h_d, al_d_q, al_d_d;
  logic [8:0]  st_s, st_m, st_h, st_d, st_w, st_mo, st_y;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // BCD step with wrap from hi back to lo; bit 8 is the carry
  function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] lo,
                                          input logic [7:0] hi);
    if (v >= hi) bcd_step = {1'b1, lo};
    else if (v[3:0] == 4'h9) bcd_step = {1'b0, v[7:4] + 4'h1, 4'h0};
    else bcd_step = {1'b0, v[7:4], v[3:0] + 4'h1};
  endfunction

  // Hour step in either format; 11 PM to 12 AM carries the day
  function automatic logic [8:0] hour_step(input logic [7:0] v, input logic m12);
    logic [8:0] t;
    t = bcd_step({3'h0, v[4:0]}, 8'h01, 8'h12);
    if (!m12) hour_step = bcd_step(v, 8'h00, 8'h23);
    else if (v[4:0] == 5'h11) hour_step = {v[5], 2'h0, ~v[5], 5'h12};
    else hour_step = {1'b0, 2'h0, v[5], t[4:0]};
  endfunction

  // Last day of the month; years divisible by four are leap years
  function automatic logic [7:0] month_len(input logic [7:0] mo, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    if (mo == 8'h02) month_len = leap ? 8'h29 : 8'h28;
    else if (mo == 8'h04 || mo == 8'h06 || mo == 8'h09 || mo == 8'h11) month_len = 8'h30;
    else month_len = 8'h31;
  endfunction

  // Oscillator domain: enable crosses in, one toggle per second goes out
  always_comb begin
    div_d = div_q;
    tg_d = tg_q;
    if (ce_o_q[1]) begin
      if (div_q >= TICK_DIV - 1) begin
        div_d = 32'h0000_0000;
        tg_d = ~tg_q;
      end else begin
        div_d = div_q + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge osc_clk or negedge rst_n) begin
    if (!rst_n) begin
      ce_o_q <= 2'h0;
      div_q <= 32'h0000_0000;
      tg_q <= 1'b0;
    end else begin
      ce_o_q <= {ce_o_q[0], ce};
      div_q <= div_d;
      tg_q <= tg_d;
    end
  end

  // Tick toggle and mode strap brought into the bus clock
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tg_s_q <= 3'h0;
      mode_s_q <= 2'h0;
    end else if (ce) begin
      tg_s_q <= {tg_s_q[1:0], tg_q};
      mode_s_q <= {mode_s_q[0], hour_12_mode};
    end
  end

  assign tick = tg_s_q[1] ^ tg_s_q[2];

  rtc_bus_slave u_bus (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .ce       (ce),
    .scl      (scl),
    .sda_i    (sda_i),
    .sda_o    (sda_o),
    .sda_oe_n (sda_oe_n),
    .busy     (busy),
    .wr_en    (wr_en),
    .wr_addr  (wr_addr),
    .wr_data  (wr_data),
    .rd_addr  (rd_addr),
    .rd_data  (rd_data)
  );

  // Read mux; unimplemented locations read zero
  always_comb begin
    if (rd_addr == rtc_pkg::OFS_SEC) rd_data = sec_q;
    else if (rd_addr == rtc_pkg::OFS_MIN) rd_data = min_q;
    else if (rd_addr == rtc_pkg::OFS_HOUR) rd_data = hr_q;
    else if (rd_addr == rtc_pkg::OFS_DAY) rd_data = day_q;
    else if (rd_addr == rtc_pkg::OFS_WDAY) rd_data = wd_q;
    else if (rd_addr == rtc_pkg::OFS_MONTH) rd_data = mon_q;
    else if (rd_addr == rtc_pkg::OFS_YEAR) rd_data = yr_q;
    else if (rd_addr == rtc_pkg::OFS_AL_SEC) rd_data = al_s_q;
    else if (rd_addr == rtc_pkg::OFS_AL_MIN) rd_data = al_m_q;
    else if (rd_addr == rtc_pkg::OFS_AL_HOUR) rd_data = al_h_q;
    else if (rd_addr == rtc_pkg::OFS_AL_DAY) rd_data = al_d_q;
    else rd_data = 8'h00;
  end

  // Time chain; only one deferred tick is kept, a second one is lost
  always_comb begin
    st_s = 9'h000; st_m = 9'h000; st_h = 9'h000; st_d = 9'h000;
    st_w = 9'h000; st_mo = 9'h000; st_y = 9'h000;
    sec_d = sec_q; min_d = min_q; hr_d = hr_q; day_d = day_q;
    wd_d = wd_q; mon_d = mon_q; yr_d = yr_q; pend_d = pend_q;
    if (busy) begin
      if (tick) pend_d = 1'b1;                  // [R3] [R4] [R5]
    end else if (tick || pend_q) begin
      // A fresh tick meeting a stored one stays stored, so neither is lost
      pend_d = tick & pend_q;                   // [R4]
      st_s = bcd_step(sec_q, 8'h00, 8'h59);
      sec_d = st_s[7:0];
      if (st_s[8]) begin
        st_m = bcd_step(min_q, 8'h00, 8'h59);
        min_d = st_m[7:0];
      end
      if (st_m[8]) begin
        st_h = hour_step(hr_q, mode_s_q[1]);
        hr_d = st_h[7:0];
      end
      if (st_h[8]) begin
        st_w = bcd_step(wd_q, 8'h00, 8'h06);
        wd_d = st_w[7:0];
        st_d = bcd_step(day_q, 8'h01, month_len(mon_q, yr_q));
        day_d = st_d[7:0];
      end
      if (st_d[8]) begin
        st_mo = bcd_step(mon_q, 8'h01, 8'h12);  // [R1]
        mon_d = st_mo[7:0];
      end
      if (st_mo[8]) begin
        st_y = bcd_step(yr_q, 8'h00, 8'h99);    // [R2]
        yr_d = st_y[7:0];
      end
    end
    if (wr_en) begin
      if (wr_addr == rtc_pkg::OFS_SEC) sec_d = wr_data & rtc_pkg::MASK_SEC;
      else if (wr_addr == rtc_pkg::OFS_MIN) min_d = wr_data & rtc_pkg::MASK_MIN;
      else if (wr_addr == rtc_pkg::OFS_HOUR) hr_d = wr_data & rtc_pkg::MASK_HOUR;
      else if (wr_addr == rtc_pkg::OFS_DAY) day_d = wr_data & rtc_pkg::MASK_DAY;
      else if (wr_addr == rtc_pkg::OFS_WDAY) wd_d = wr_data & rtc_pkg::MASK_WDAY;
      else if (wr_addr == rtc_pkg::OFS_MONTH) mon_d = wr_data & rtc_pkg::MASK_MONTH; // [R1]
      else if (wr_addr == rtc_pkg::OFS_YEAR) yr_d = wr_data & rtc_pkg::MASK_YEAR;    // [R2]
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sec_q <= rtc_pkg::RST_SEC;    min_q <= rtc_pkg::RST_MIN;
      hr_q <= rtc_pkg::RST_HOUR;    day_q <= rtc_pkg::RST_DAY;
      wd_q <= rtc_pkg::RST_WDAY;    mon_q <= rtc_pkg::RST_MONTH;  // [R1]
      yr_q <= rtc_pkg::RST_YEAR;    pend_q <= 1'b0;               // [R2]
    end else if (ce) begin
      sec_q <= sec_d;  min_q <= min_d;  hr_q <= hr_d;  day_q <= day_d;
      wd_q <= wd_d;    mon_q <= mon_d;  yr_q <= yr_d;  pend_q <= pend_d;
    end
  end

  // Alarm registers and compare; a disabled field never blocks a match unless all four fields are disabled
  always_comb begin
    al_s_d = al_s_q;
    al_m_d = al_m_q;
    al_h_d = al_h_q;
    al_d_d = al_d_q;
    if (wr_en) begin
      if (wr_addr == rtc_pkg::OFS_AL_SEC) al_s_d = wr_data & rtc_pkg::MASK_AL_SMH;      // [R8]
      else if (wr_addr == rtc_pkg::OFS_AL_MIN) al_m_d = wr_data & rtc_pkg::MASK_AL_SMH; // [R9]
      else if (wr_addr == rtc_pkg::OFS_AL_HOUR) al_h_d = wr_data & rtc_pkg::MASK_AL_HD; // [R10]
      else if (wr_addr == rtc_pkg::OFS_AL_DAY) al_d_d = wr_data & rtc_pkg::MASK_AL_HD;  // [R11]
    end
    // Hour fields share one coding in both formats, so bits 5..0 compare [R10] [R12]
    alarm_d = ~(al_s_q[7] & al_m_q[7] & al_h_q[7] & al_d_q[7])
            & (al_s_q[7] | (al_s_q[6:0] == sec_q[6:0]))
            & (al_m_q[7] | (al_m_q[6:0] == min_q[6:0]))
            & (al_h_q[7] | (al_h_q[5:0] == hr_q[5:0]))
            & (al_d_q[7] | (al_d_q[5:0] == day_q[5:0]));
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      al_s_q <= rtc_pkg::RST_ALARM;  al_m_q <= rtc_pkg::RST_ALARM;
      al_h_q <= rtc_pkg::RST_ALARM;  al_d_q <= rtc_pkg::RST_ALARM;
      alarm_q <= 1'b0;
    end else if (ce) begin
      al_s_q <= al_s_d;  al_m_q <= al_m_d;
      al_h_q <= al_h_d;  al_d_q <= al_d_d;
      alarm_q <= alarm_d;
    end
  end

  assign alarm = alarm_q;

  // Checks
  month_write_a: assert property (ce && wr_en && wr_addr == rtc_pkg::OFS_MONTH |=>  // [R1]
    mon_q == ($past(wr_data) & rtc_pkg::MASK_MONTH)) else $error("month write wrong");
  year_roll_a: assert property (ce && !wr_en && st_mo[8] && yr_q[3:0] == 4'h9 |=>   // [R2]
    yr_q == (($past(yr_q[7:4]) == 4'h9) ? 8'h00 : {$past(yr_q[7:4]) + 4'h1, 4'h0}))
    else $error("year digit carry wrong");
  freeze_hold_a: assert property (ce && busy && !wr_en |=>                          // [R3]
    sec_q == $past(sec_q) && min_q == $past(min_q) && yr_q == $past(yr_q))
    else $error("time moved during access");
  pend_keep_a: assert property (ce && busy && tick |=> pend_q ##0 $stable(sec_q) or  // [R4]
    !ce) else $error("deferred tick not stored");
  pend_apply_a: assert property (ce && !busy && pend_q && !tick && !wr_en |=>       // [R4]
    !pend_q && sec_q != $past(sec_q)) else $error("deferred tick not applied");
  sec_alarm_a: assert property (alarm_q |->                                        // [R8]
    $past(al_s_q[7] || al_s_q[6:0] == sec_q[6:0])) else $error("second alarm mismatch");
  min_alarm_a: assert property (alarm_q |->                                        // [R9]
    $past(al_m_q[7] || al_m_q[6:0] == min_q[6:0])) else $error("minute alarm mismatch");
  hour_bit_a: assert property (ce && wr_en && wr_addr == rtc_pkg::OFS_AL_HOUR |=>   // [R10]
    al_h_q[6] == 1'b0 && al_h_q[7] == $past(wr_data[7])) else $error("hour alarm bits");
  day_bit_a: assert property (ce && wr_en && wr_addr == rtc_pkg::OFS_AL_DAY |=>     // [R11]
    al_d_q[6] == 1'b0 && al_d_q[7] == $past(wr_data[7]) && al_d_q[5:0] == $past(wr_data[5:0]))
    else $error("day alarm bits");
  alarm_cause_a: assert property (ce && alarm_d |=> // [R12]
    alarm_q ##1 (alarm_q || !$past(alarm_d))) else $error("alarm not raised on match");
  alarm_none_a: assert property (ce && al_s_q[7] && al_m_q[7] && al_h_q[7] // [R12]
    && al_d_q[7] |=> !alarm_q) else $error("alarm with all fields off");
endmodule

//--- logic/rtc_pkg.sv
package rtc_pkg;
  // Bus identity and register locations
  localparam logic [6:0] DEV_ADDR     = 7'h51;
  localparam logic [7:0] OFS_SEC      = 8'h04;
  localparam logic [7:0] OFS_MIN      = 8'h05;
  localparam logic [7:0] OFS_HOUR     = 8'h06;
  localparam logic [7:0] OFS_DAY      = 8'h07;
  localparam logic [7:0] OFS_WDAY     = 8'h08;
  localparam logic [7:0] OFS_MONTH    = 8'h09;
  localparam logic [7:0] OFS_YEAR     = 8'h0a;
  localparam logic [7:0] OFS_AL_SEC   = 8'h0b;
  localparam logic [7:0] OFS_AL_MIN   = 8'h0c;
  localparam logic [7:0] OFS_AL_HOUR  = 8'h0d;
  localparam logic [7:0] OFS_AL_DAY   = 8'h0e;
  // Reset values
  localparam logic [7:0] RST_SEC      = 8'h00;
  localparam logic [7:0] RST_MIN      = 8'h00;
  localparam logic [7:0] RST_HOUR     = 8'h00;
  localparam logic [7:0] RST_DAY      = 8'h01;
  localparam logic [7:0] RST_WDAY     = 8'h06;
  localparam logic [7:0] RST_MONTH    = 8'h01;
  localparam logic [7:0] RST_YEAR     = 8'h00;
  localparam logic [7:0] RST_ALARM    = 8'h80;
  // Writable bits of each register
  localparam logic [7:0] MASK_SEC     = 8'h7f;
  localparam logic [7:0] MASK_MIN     = 8'h7f;
  localparam logic [7:0] MASK_HOUR    = 8'h3f;
  localparam logic [7:0] MASK_DAY     = 8'h3f;
  localparam logic [7:0] MASK_WDAY    = 8'h07;
  localparam logic [7:0] MASK_MONTH   = 8'h1f;
  localparam logic [7:0] MASK_YEAR    = 8'hff;
  localparam logic [7:0] MASK_AL_SMH  = 8'hff;
  localparam logic [7:0] MASK_AL_HD   = 8'hbf;
  // Field positions
  localparam int unsigned MATCH_OFF_BIT = 7;
  localparam int unsigned MERIDIEM_BIT  = 5;
  // Oscillator cycles per one-second tick
  localparam int unsigned TICK_DIV_DEF  = 4096;
  // Bus engine states
  typedef enum logic [2:0] {
    RTC_IDLE, RTC_ADDR, RTC_RX, RTC_ACK, RTC_TX, RTC_MACK
  } rtc_bus_state_t;
endpackage

//--- logic/rtc_bus_slave.sv
`timescale 1ns/10ps
module rtc_bus_slave (
  // Clock, reset, enable
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // Serial bus pins
  input  wire logic       scl,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n,
  // Register side
  output logic            busy,
  output logic            wr_en,
  output logic [7:0]      wr_addr,
  output logic [7:0]      wr_data,
  output logic [7:0]      rd_addr,
  input  wire logic [7:0] rd_data
);
  logic [2:0]               scl_s_q, sda_s_q;
  logic                     start, stop, rise, fall;
  rtc_pkg::rtc_bus_state_t  st_q, st_d;
  logic [2:0]               cnt_q, cnt_d;
  logic [7:0]               sh_q, sh_d, ptr_q, ptr_d, wa_q, wa_d, wd_q, wd_d;
  logic                     full_q, full_d, rw_q, rw_d, first_q, first_d;
  logic                     nack_q, nack_d, oe_n_q, oe_n_d, busy_q, busy_d, we_q, we_d;

  // Pin sampling: stage 0 feeds only stage 1, stage 2 is the previous value
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
    end else if (ce) begin
      scl_s_q <= {scl_s_q[1:0], scl};
      sda_s_q <= {sda_s_q[1:0], sda_i};
    end
  end

  assign start = scl_s_q[1] & sda_s_q[2] & ~sda_s_q[1];
  assign stop  = scl_s_q[1] & ~sda_s_q[2] & sda_s_q[1];
  assign rise  = scl_s_q[1] & ~scl_s_q[2];
  assign fall  = ~scl_s_q[1] & scl_s_q[2];

  // Bit and byte engine; open drain, so a one is sent by releasing
  always_comb begin
    st_d = st_q;  cnt_d = cnt_q; sh_d = sh_q; ptr_d = ptr_q;
    wa_d = wa_q;  wd_d = wd_q;   full_d = full_q; rw_d = rw_q;
    first_d = first_q; nack_d = nack_q; oe_n_d = oe_n_q;
    busy_d = busy_q;   we_d = 1'b0;
    if (stop) begin
      st_d = rtc_pkg::RTC_IDLE;
      oe_n_d = 1'b1;
      busy_d = 1'b0;                     // Access ends at stop or at a start naming another device [R3] [R6]
    end else if (start) begin
      // Pointer survives a repeated start so a read can follow it [R7]
      st_d = rtc_pkg::RTC_ADDR;
      cnt_d = 3'h0;
      full_d = 1'b0;
      first_d = 1'b1;
      oe_n_d = 1'b1;
    end else begin
      case (st_q)
        rtc_pkg::RTC_ADDR, rtc_pkg::RTC_RX: begin
          if (rise) begin
            sh_d = {sh_q[6:0], sda_s_q[1]};
            cnt_d = cnt_q + 3'h1;
            full_d = (cnt_q == 3'h7);
          end else if (fall && full_q) begin
            full_d = 1'b0;
            oe_n_d = 1'b0;
            st_d = rtc_pkg::RTC_ACK;
            if (st_q == rtc_pkg::RTC_ADDR) begin
              if (sh_q[7:1] == rtc_pkg::DEV_ADDR) begin
                busy_d = 1'b1;           // Counters frozen from here [R3]
                rw_d = sh_q[0];
              end else begin
                busy_d = 1'b0;
                oe_n_d = 1'b1;
                st_d = rtc_pkg::RTC_IDLE;
              end
            end else if (first_q) begin
              ptr_d = sh_q;
              first_d = 1'b0;
            end else begin
              we_d = 1'b1;
              wa_d = ptr_q;
              wd_d = sh_q;
              ptr_d = ptr_q + 8'h01;
            end
          end
        end
        rtc_pkg::RTC_ACK: begin
          if (fall) begin
            cnt_d = 3'h0;
            if (rw_q) begin
              sh_d = rd_data;
              oe_n_d = rd_data[7];
              st_d = rtc_pkg::RTC_TX;
            end else begin
              oe_n_d = 1'b1;
              st_d = rtc_pkg::RTC_RX;
            end
          end
        end
        rtc_pkg::RTC_TX: begin
          if (rise) begin
            cnt_d = cnt_q + 3'h1;
            full_d = (cnt_q == 3'h7);
          end else if (fall) begin
            if (full_q) begin
              full_d = 1'b0;
              oe_n_d = 1'b1;
              ptr_d = ptr_q + 8'h01;
              st_d = rtc_pkg::RTC_MACK;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              oe_n_d = sh_q[6];
            end
          end
        end
        rtc_pkg::RTC_MACK: begin
          if (rise) begin
            nack_d = sda_s_q[1];
          end else if (fall) begin
            if (nack_q) begin
              st_d = rtc_pkg::RTC_IDLE;
            end else begin
              sh_d = rd_data;
              oe_n_d = rd_data[7];
              cnt_d = 3'h0;
              st_d = rtc_pkg::RTC_TX;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Engine registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= rtc_pkg::RTC_IDLE;
      cnt_q <= 3'h0;     sh_q <= 8'h00;   ptr_q <= 8'h00;
      wa_q <= 8'h00;     wd_q <= 8'h00;   full_q <= 1'b0;
      rw_q <= 1'b0;      first_q <= 1'b0; nack_q <= 1'b1;
      oe_n_q <= 1'b1;    busy_q <= 1'b0;  we_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      cnt_q <= cnt_d;    sh_q <= sh_d;    ptr_q <= ptr_d;
      wa_q <= wa_d;      wd_q <= wd_d;    full_q <= full_d;
      rw_q <= rw_d;      first_q <= first_d; nack_q <= nack_d;
      oe_n_q <= oe_n_d;  busy_q <= busy_d; we_q <= we_d;
    end
  end

  assign sda_o    = 1'b0;                // Only ever pulls low
  assign sda_oe_n = oe_n_q;
  assign busy     = busy_q;
  assign wr_en    = we_q;
  assign wr_addr  = wa_q;
  assign wr_data  = wd_q;
  assign rd_addr  = ptr_q;
endmodule

//--- test/rtc_bus_master.sv
`timescale 1ns/10ps
module rtc_bus_master (
  // Pacing clock
  input  wire logic clk,
  // Bus pins, data is open drain
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // Bytes received, bytes to send, missing acknowledges
  logic [7:0] rx [$];
  logic [7:0] tx [$];
  int         nacks;

  // Idle bus at time zero: both lines released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    nacks = 0;
  end

  // Launch just after an edge so the device never sees a race
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One bit: data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    wt(6);
    sda_low = !b;
    wt(19);
    scl = 1'b1;
    wt(25);
    r = sda;
    scl = 1'b0;
  endtask

  // Start or repeated start: data falls while clock high
  task automatic start();
    wt(6);
    sda_low = 1'b0;
    wt(19);
    scl = 1'b1;
    wt(25);
    sda_low = 1'b1;
    wt(25);
    scl = 1'b0;
  endtask

  // Stop: data rises while clock high, then the bus rests
  task automatic stop();
    wt(6);
    sda_low = 1'b1;
    wt(19);
    scl = 1'b1;
    wt(25);
    sda_low = 1'b0;
    wt(25);
  endtask

  // Byte MSB first plus the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic nk, input logic chk,
                      output logic [7:0] q);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(nk, r);
    if (chk && r) nacks++;
  endtask

  // Address for write, pointer, then turn round for reading
  task automatic access(input logic [7:0] ptr, input logic rd);
    logic [7:0] q;
    start();
    xfer({rtc_pkg::DEV_ADDR, 1'b0}, 1'b1, 1'b1, q);
    xfer(ptr, 1'b1, 1'b1, q);
    if (rd) begin
      start();
      xfer({rtc_pkg::DEV_ADDR, 1'b1}, 1'b1, 1'b1, q);
    end
  endtask

  // Whole block in one access, closed well inside one tick
  task automatic get(input int n);
    logic [7:0] q;
    rx = {};
    for (int i = 0; i < n; i++) begin
      xfer(8'hff, i == n - 1, 1'b0, q);
      rx.push_back(q);
    end
    stop();
  endtask

  // Burst write of the queued bytes in one access
  task automatic put();
    logic [7:0] q;
    foreach (tx[i]) xfer(tx[i], 1'b1, 1'b1, q);
    stop();
  endtask
endmodule

//--- test/test_rtc_calendar.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_rtc_calendar;
  // Short tick so a second costs eight time-base cycles
  localparam int DIV = 8;
  logic mclk, rst_n, ce, osc_clk, hour_12_mode;
  logic scl, m_low, sda_w, sda_o, sda_oe_n, alarm;
  int   fail_count = 0;
  int   num_checks = 0;
  int   cyc = 0;

  // Pull-up wire shared by both open-drain drivers
  assign sda_w = (sda_oe_n | sda_o) & ~m_low;

  rtc_calendar #(.TICK_DIV(DIV)) i_dut (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .osc_clk(osc_clk),
    .hour_12_mode(hour_12_mode), .scl(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .alarm(alarm));
  rtc_bus_master i_m (.clk(mclk), .scl(scl), .sda_low(m_low), .sda(sda_w));

  // Bus-side clock
  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  // Time base runs only on demand, so tick counts stay exact
  task automatic osc_cycles(input int n);
    repeat (n) begin
      #7.5 osc_clk = 1'b1;
      #7.5 osc_clk = 1'b0;
    end
  endtask

  // Any DIV consecutive cycles hold exactly one tick
  task automatic tick();
    osc_cycles(DIV);
    i_m.wt(10);
  endtask

  task automatic wr1(input logic [7:0] ptr, input logic [7:0] v);
    i_m.tx = '{v};
    i_m.access(ptr, 1'b0);
    i_m.put();
    i_m.wt(10);
  endtask

  task automatic rd(input logic [7:0] ptr, input int n);
    i_m.access(ptr, 1'b1);
    i_m.get(n);
  endtask

  task automatic cmp_rx(input logic [7:0] e [$]);
    foreach (e[i]) `CHK(i_m.rx[i], e[i])
  endtask

  // Defaults, an unmapped location first
  task automatic t_reset();
    rd(8'h03, 12);
    cmp_rx('{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h06, 8'h01, 8'h00,
             8'h80, 8'h80, 8'h80, 8'h80});
    `CHK(alarm, 1'b0)
    $display("test reset done");
  endtask

  // Full carry from the last second of year 99, the last of the century
  task automatic t_carry();
    i_m.tx = '{8'h59, 8'h59, 8'h23, 8'h31, 8'h06, 8'h12, 8'h99};
    i_m.access(8'h04, 1'b0);
    i_m.put();
    tick();
    rd(8'h04, 7);
    cmp_rx('{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00});
    $display("test carry done");
  endtask

  // Two ticks inside one access: frozen, then only one applied
  task automatic t_freeze();
    wr1(8'h04, 8'h00);
    i_m.access(8'h04, 1'b1);
    osc_cycles(2 * DIV);
    i_m.wt(10);
    i_m.get(1);
    cmp_rx('{8'h00});
    i_m.wt(10);
    rd(8'h04, 2);
    cmp_rx('{8'h01, 8'h00});
    $display("test freeze done");
  endtask

  // Alarm fields, enables and the 12-hour hour match
  task automatic t_alarm();
    hour_12_mode = 1'b1;
    i_m.tx = '{8'h59, 8'h59, 8'h11, 8'h15, 8'h00, 8'h01, 8'h00,
               8'h80, 8'h00, 8'h72, 8'h55};
    i_m.access(8'h04, 1'b0);
    i_m.put();
    i_m.wt(10);
    `CHK(alarm, 1'b0)
    rd(8'h0d, 2);
    cmp_rx('{8'h32, 8'h15});
    tick();
    `CHK(alarm, 1'b1)
    wr1(8'h0b, 8'h05);
    `CHK(alarm, 1'b0)
    wr1(8'h0b, 8'h00);
    `CHK(alarm, 1'b1)
    rd(8'h04, 3);
    cmp_rx('{8'h00, 8'h00, 8'h32});
    $display("test alarm done");
  endtask

  // Enable low: bus deaf, divider and time frozen; one tick per second after
  task automatic t_hold();
    int n;
    n = i_m.nacks;
    ce = 1'b0;
    osc_cycles(DIV);
    i_m.wt(1);
    wr1(8'h04, 8'h33);
    `CHK(alarm, 1'b1)
    `CHK(i_m.nacks - n, 3)
    i_m.nacks = n;
    ce = 1'b1;
    i_m.wt(3);
    rd(8'h04, 1);
    cmp_rx('{8'h00});
    tick();
    rd(8'h04, 1);
    cmp_rx('{8'h01});
    $display("test hold done");
  endtask

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hang guard, about twice the expected run
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      fail_count++;
      end_of_test();
    end
  end

  // Reset with the time base clocked, then the tests in turn
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    osc_clk = 1'b0;
    hour_12_mode = 1'b0;
    fork
      osc_cycles(2);
      repeat (8) @(posedge mclk);
    join
    #1;
    rst_n = 1'b1;
    osc_cycles(2);
    i_m.wt(3);
    t_reset();
    t_carry();
    t_freeze();
    t_alarm();
    t_hold();
    `CHK(i_m.nacks, 0)
    end_of_test();
  end
endmodule
